//--- rtl/eep_slave.v
// Two-wire slave port of a 256 x 8 erasable memory
// How the port works
// Both bus lines and the three straps are pins, so each passes a
// two-stage synchroniser before any logic reads it. The serial clock
// is never used as a clock: its edges are found by comparing the
// synchronised level with its value one cycle earlier.
//
// A start or stop is a data edge while the serial clock stays high.
// Either one clears the bit counter and releases the data line, so a
// frame cut short by the master never leaves the line pulled low.
//
// Every frame has nine pulses. Pulses one to eight shift a bit in on
// the rising edge. On the eighth rise the byte is decoded and the
// answer for the ninth pulse is chosen. The ninth rise closes the
// frame; in a read it also samples the master's acknowledge.
//
// The line is only ever pulled low or released, never driven high.
// A new level is applied a fixed hold time after each clock fall, so
// the previous bit still stands while the master's falling edge is
// uncertain. The hold is far shorter than the clock low time at the
// fastest serial rate, so the new bit is set up well before the rise.
//
// Writes: the first byte after the address loads the pointer and the
// start address of the pending write; up to two data bytes are kept
// in a small buffer and acknowledged; any further byte is refused.
// Nothing reaches the array until the stop: then the busy flag rises
// and a countdown runs for one period per buffered byte. The buffered
// bytes are committed in the last cycle of the countdown, so a read
// can never see half of a two-byte write.
//
// While busy the port sits in its programming state: it follows the
// frames so that it stays in step with the bus, but it never pulls the
// line, so its address goes unanswered. Once the countdown is done
// the port returns to idle and waits for the next start.
//
// Reads: each byte is fetched from the array on the clock fall that
// opens its frame, and the pointer then advances by one. A missing
// acknowledge from the master ends the read: the line stays released
// so that the master can send its stop.
//
// The pointer wraps from the top location back to zero, both when it
// advances and when the second byte of a write lands.
//
// Limitations: the programming time is a count of clock cycles, not
// an analogue timer, so the timer constant pin is only a marker here.
// A start that arrives during the single cycle in which programming
// ends is taken as a frame of the programming state and goes
// unanswered; the master simply retries.
`timescale 1ns/1ps
`include "eep_consts.vh"
module eep_slave #(
    parameter AW = 8, // Word address width
    parameter DW = 8, // Data width
    parameter MS_CYCLES = 250000, // Clock cycles per millisecond
    parameter PROG_MS_PER_BYTE = `EEP_BYTE_MS // Programming time per byte
) (
    input wire CLOCK, // System clock
    input wire SRST, // Synchronous reset, high
    input wire SCL_I, // Serial clock from the bus
    input wire SDA_I, // Serial data level on the bus
    output wire SDA_O, // Serial data drive value, always low
    output reg SDA_OE_N, // Data pull enable, low pulls low
    input wire CHIP_SELECT_STRAP_0, // Address strap bit 0
    input wire CHIP_SELECT_STRAP_1, // Address strap bit 1
    input wire CHIP_SELECT_STRAP_2, // Address strap bit 2
    input wire PROGRAM_TIMER_CONSTANT_INPUT, // Timer constant present; unused by logic model
    output reg BUSY, // Programming cycle in progress
    output reg [AW-1:0] POINTER // Current word address
);
    // Hold count after a clock fall, rounded up, at least one cycle
    localparam HOLD_CYC = (`EEP_HOLD_NS * `EEP_CLK_MHZ + 999) / 1000;
    localparam [7:0] HOLD_W = HOLD_HELPER(HOLD_CYC);
    localparam PROG_CYC = MS_CYCLES * PROG_MS_PER_BYTE;
    localparam [31:0] PROG_W = PROG_CYC;

    function [7:0] HOLD_HELPER;
        input integer n;
        begin
            HOLD_HELPER = (n < 1) ? 8'h01 : n[7:0];
        end
    endfunction

    // Next word address, wrapping from the top to zero
    function [AW-1:0] ptr_next;
        input [AW-1:0] p; // Current address
        begin
            ptr_next = p + {{(AW-1){1'b0}}, 1'b1};
        end
    endfunction

    wire scl_s, scl_p, sda_s, sda_p; // Synchronised lines and history
    reg [2:0] state_r, state_nxt; // Transfer state
    reg [3:0] bit_r; // Bit position in current nine-pulse frame
    reg [DW-1:0] shift_r; // Receive or transmit shift register
    reg ack_slot_r; // Acknowledge slot pending drive
    reg drive_ack_r; // We acknowledge this slot
    reg [1:0] nbytes_r; // Data bytes received this write
    reg [DW-1:0] wbuf_r [0:1]; // Data waiting to be programmed
    reg [AW-1:0] wadr_r; // Start address of pending program
    reg [DW-1:0] mem_r [0:(1<<AW)-1]; // Storage array
    reg [31:0] prog_cnt_r; // Programming countdown
    reg [1:0] prog_left_r; // Bytes still to commit
    reg [7:0] hold_cnt_r; // Output hold countdown
    reg out_nxt_r; // Output level waiting for hold
    reg master_nack_r; // Master withheld acknowledge

    eep_sync u_scl (.clk(CLOCK), .srst(SRST), .din(SCL_I), .dout(scl_s), .dprev(scl_p));
    eep_sync u_sda (.clk(CLOCK), .srst(SRST), .din(SDA_I), .dout(sda_s), .dprev(sda_p));

    // Strap pins are external levels too, so they are synchronised before use
    wire strap0_s, strap1_s, strap2_s; // Synchronised strap levels
    eep_sync u_st0 (.clk(CLOCK), .srst(SRST), .din(CHIP_SELECT_STRAP_0), .dout(strap0_s), .dprev());
    eep_sync u_st1 (.clk(CLOCK), .srst(SRST), .din(CHIP_SELECT_STRAP_1), .dout(strap1_s), .dprev());
    eep_sync u_st2 (.clk(CLOCK), .srst(SRST), .din(CHIP_SELECT_STRAP_2), .dout(strap2_s), .dprev());

    // Bus events; sampling at clock rate covers any serial rate up to 100 kHz
    wire start_ev = scl_s & scl_p & sda_p & ~sda_s;
    wire stop_ev = scl_s & scl_p & ~sda_p & sda_s;
    wire scl_rise = scl_s & ~scl_p; // Bit sample point
    wire scl_fall = ~scl_s & scl_p; // Change point
    // Own slave address: fixed type code, then the straps
    wire [6:0] my_addr = {`EEP_DEV_TYPE, strap2_s, strap1_s, strap0_s};
    wire [DW-1:0] rx_byte = {shift_r[DW-2:0], sda_s}; // Byte completed on eighth rise

    assign SDA_O = 1'b0;

    // Next state on a bus condition, start or stop
    always @* begin
        state_nxt = state_r;
        if (stop_ev) begin
            if (state_r == `EEP_ST_WDAT && nbytes_r != 2'd0)
                state_nxt = `EEP_ST_PROG;
            else if (state_r != `EEP_ST_PROG)
                state_nxt = `EEP_ST_IDLE;
        end else if (start_ev) begin
            if (state_r != `EEP_ST_PROG)
                state_nxt = `EEP_ST_ADDR;
        end
    end

    // Main serial engine
    always @(posedge CLOCK) begin
        if (SRST) begin
            state_r <= `EEP_ST_IDLE;
            bit_r <= 4'h0;
            shift_r <= {DW{1'b0}};
            ack_slot_r <= 1'b0;
            drive_ack_r <= 1'b0;
            nbytes_r <= 2'd0;
            wadr_r <= {AW{1'b0}};
            POINTER <= {AW{1'b0}};
            master_nack_r <= 1'b0;
            out_nxt_r <= 1'b1;
            wbuf_r[0] <= {DW{1'b0}};
            wbuf_r[1] <= {DW{1'b0}};
        end else if (stop_ev || start_ev) begin
            // Control condition restarts the frame; a start opens an address frame from any state but programming
            state_r <= state_nxt;
            bit_r <= 4'h0;
            ack_slot_r <= 1'b0;
            drive_ack_r <= 1'b0;
            out_nxt_r <= 1'b1;
            master_nack_r <= 1'b0;
            if (start_ev && state_r != `EEP_ST_PROG)
                nbytes_r <= 2'd0;
            // A stray start during programming is seen as a new frame in the busy state
            if (start_ev && state_r == `EEP_ST_PROG)
                bit_r <= 4'h0;
        end else if (state_r == `EEP_ST_IDLE) begin
            out_nxt_r <= 1'b1;
        end else if (state_r == `EEP_ST_PROG && !BUSY) begin
            // Programming done: answer the address again from the next start
            state_r <= `EEP_ST_IDLE;
            out_nxt_r <= 1'b1;
        end else if (scl_rise) begin
            if (bit_r <= `EEP_BIT_LAST) begin
                shift_r <= rx_byte;
                bit_r <= bit_r + 4'd1;
                if (bit_r == `EEP_BIT_LAST) begin
                    ack_slot_r <= 1'b1; // Ninth pulse follows
                    case (state_r)
                        `EEP_ST_ADDR: begin
                            if (rx_byte[7:1] == my_addr) begin
                                drive_ack_r <= 1'b1;
                                state_r <= rx_byte[0] ? `EEP_ST_READ : `EEP_ST_WADR;
                            end else begin
                                state_r <= `EEP_ST_IDLE;
                            end
                        end
                        `EEP_ST_PROG: begin
                            drive_ack_r <= 1'b0; // Busy: no address acknowledge
                        end
                        `EEP_ST_WADR: begin
                            POINTER <= rx_byte;
                            wadr_r <= rx_byte;
                            drive_ack_r <= 1'b1;
                            state_r <= `EEP_ST_WDAT;
                        end
                        `EEP_ST_WDAT: begin
                            if (nbytes_r < `EEP_BYTES_MAX) begin
                                wbuf_r[nbytes_r[0]] <= rx_byte;
                                nbytes_r <= nbytes_r + 2'd1;
                                POINTER <= ptr_next(POINTER);
                                drive_ack_r <= 1'b1;
                            end else begin
                                drive_ack_r <= 1'b0; // Extra bytes are refused
                            end
                        end
                        `EEP_ST_READ: begin
                            drive_ack_r <= 1'b0; // Master acknowledges here
                        end
                        default: begin
                            drive_ack_r <= 1'b0;
                        end
                    endcase
                end
            end else begin
                // Acknowledge pulse high: in read mode check master's reply
                if (state_r == `EEP_ST_READ)
                    master_nack_r <= sda_s;
                bit_r <= 4'h0;
                ack_slot_r <= 1'b0;
            end
        end else if (scl_fall) begin
            // Choose next output level; released by default
            out_nxt_r <= 1'b1;
            if (ack_slot_r && drive_ack_r) begin
                out_nxt_r <= 1'b0; // Low through ack clock high
            end else if (ack_slot_r) begin
                out_nxt_r <= 1'b1; // Transmitter releases for ack
            end else if (state_r == `EEP_ST_READ && bit_r == 4'h0) begin
                if (master_nack_r) begin
                    out_nxt_r <= 1'b1; // Leave high so master can stop
                    state_r <= `EEP_ST_IDLE;
                end else begin
                    shift_r <= mem_r[POINTER];
                    out_nxt_r <= mem_r[POINTER][DW-1];
                    POINTER <= ptr_next(POINTER);
                end
            end else if (state_r == `EEP_ST_READ) begin
                out_nxt_r <= shift_r[DW-1];
            end
            if (ack_slot_r)
                drive_ack_r <= drive_ack_r;
        end
    end

    // Output register with hold delay after each clock fall
    always @(posedge CLOCK) begin
        if (SRST) begin
            SDA_OE_N <= 1'b1;
            hold_cnt_r <= 8'h00;
        end else if (start_ev || stop_ev) begin
            SDA_OE_N <= 1'b1;
            hold_cnt_r <= 8'h00;
        end else if (scl_fall) begin
            hold_cnt_r <= HOLD_W;
        end else if (hold_cnt_r != 8'h00) begin
            hold_cnt_r <= hold_cnt_r - 8'h01;
            if (hold_cnt_r == 8'h01)
                SDA_OE_N <= out_nxt_r;
        end
    end

    // Self-timed programming after the stop
    always @(posedge CLOCK) begin
        if (SRST) begin
            BUSY <= 1'b0;
            prog_cnt_r <= 32'h0;
            prog_left_r <= 2'd0;
        end else if (!BUSY && state_r == `EEP_ST_WDAT && stop_ev && nbytes_r != 2'd0) begin
            BUSY <= 1'b1;
            prog_cnt_r <= PROG_W;
            prog_left_r <= nbytes_r;
        end else if (BUSY) begin
            if (prog_cnt_r != 32'h0) begin
                prog_cnt_r <= prog_cnt_r - 32'h1;
            end else if (prog_left_r == 2'd2) begin
                prog_left_r <= 2'd1; // Second byte takes another period
                prog_cnt_r <= PROG_W - 32'h1; // This cycle already counts toward it
            end else begin
                BUSY <= 1'b0;
                prog_left_r <= 2'd0;
            end
        end
    end

    // Commit pending bytes to the array when programming ends
    always @(posedge CLOCK) begin
        if (BUSY && prog_cnt_r == 32'h0 && prog_left_r != 2'd2) begin
            mem_r[wadr_r] <= wbuf_r[0];
            if (nbytes_r == `EEP_BYTES_MAX)
                mem_r[ptr_next(wadr_r)] <= wbuf_r[1];
        end
    end
endmodule // eep_slave

//--- rtl/eep_consts.vh
// Constants shared by the serial memory slave port
`ifndef EEP_CONSTS_VH
`define EEP_CONSTS_VH
`define EEP_CLK_MHZ 250
`define EEP_HOLD_NS 300
`define EEP_BYTE_MS 30
`define EEP_BYTES_MAX 2'd2
`define EEP_DEV_TYPE 4'ha
`define EEP_BIT_LAST 4'd7
`define EEP_BIT_ACK 4'd8
`define EEP_ST_IDLE 3'd0
`define EEP_ST_ADDR 3'd1
`define EEP_ST_WADR 3'd2
`define EEP_ST_WDAT 3'd3
`define EEP_ST_READ 3'd4
`define EEP_ST_PROG 3'd5
`endif

//--- rtl/eep_sync.v
// Two-stage synchroniser with one cycle of history on the second stage
`timescale 1ns/1ps
module eep_sync (
    input wire clk, // Sampling clock
    input wire srst, // Synchronous reset
    input wire din, // Asynchronous level
    output reg dout, // Synchronised level
    output reg dprev // Level one cycle earlier
);
    reg meta_r; // First stage, read only by dout
    // Resolve and keep one cycle of history; lines idle high
    always @(posedge clk) begin
        if (srst) begin
            meta_r <= 1'b1;
            dout <= 1'b1;
            dprev <= 1'b1;
        end else begin
            meta_r <= din;
            dout <= meta_r;
            dprev <= dout;
        end
    end
endmodule // eep_sync

//--- dv/eep_slave_chk.sv
// Assertion checker for the two-wire memory slave port
`timescale 1ns/1ps
module eep_slave_chk #(
    parameter MS_CYCLES = 250000, // Clock cycles per millisecond
    parameter PROG_MS_PER_BYTE = 30 // Programming time per byte
) (
    input wire CLOCK, // System clock
    input wire SRST, // Synchronous reset
    input wire SCL_I, // Serial clock
    input wire SDA_I, // Data line level
    input wire SDA_O, // Drive value
    input wire SDA_OE_N, // Pull enable, low pulls
    input wire BUSY, // Programming flag
    input wire [7:0] POINTER // Word address
);
    localparam integer ONE_B = MS_CYCLES * PROG_MS_PER_BYTE; // Cycles for one byte
    integer busy_cnt; // Length of the running programming cycle
    // Count cycles while programming runs
    always @(posedge CLOCK) begin
        if (SRST || !BUSY) begin
            busy_cnt <= 0;
        end else begin
            busy_cnt <= busy_cnt + 1;
        end
    end
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (SRST);
    chk_reset_idle: assert property (disable iff (1'b0) $fell(SRST) |-> SDA_OE_N && !BUSY && POINTER == 8'h00)
        else $error("port not idle after reset");
    chk_high_stable: assert property ($rose(SCL_I) |=> $stable(SDA_OE_N) [*8])
        else $error("data drive moved in clock high");
    chk_fall_hold: assert property ($fell(SCL_I) |=> $stable(SDA_OE_N) [*8])
        else $error("data drive moved inside hold");
    chk_busy_after_stop: assert property ($rose(BUSY) |-> SCL_I && SDA_I)
        else $error("programming began outside stop");
    chk_busy_no_ack: assert property (BUSY |-> SDA_OE_N)
        else $error("line pulled while programming");
    chk_busy_pointer: assert property (BUSY && $past(BUSY) |-> $stable(POINTER))
        else $error("pointer moved while programming");
    chk_busy_length: assert property ($fell(BUSY) |-> (busy_cnt >= ONE_B - 1 && busy_cnt <= ONE_B + 1)
        || (busy_cnt >= 2 * ONE_B - 1 && busy_cnt <= 2 * ONE_B + 1))
        else $error("programming length wrong");
    chk_drive_low: assert property (!SDA_OE_N |-> SDA_O == 1'b0)
        else $error("drive value not low");
endmodule // eep_slave_chk
bind eep_slave eep_slave_chk #(.MS_CYCLES(MS_CYCLES), .PROG_MS_PER_BYTE(PROG_MS_PER_BYTE)) u_chk (.CLOCK(CLOCK),
    .SRST(SRST), .SCL_I(SCL_I), .SDA_I(SDA_I), .SDA_O(SDA_O), .SDA_OE_N(SDA_OE_N), .BUSY(BUSY), .POINTER(POINTER));

//--- dv/eep_master.sv
// Behavioural two-wire bus master driving the slave port
`timescale 1ns/1ps
module eep_master #(
    parameter LOW = 100, // Clock low cycles, longer than the slave hold
    parameter HIGH = 20 // Clock high cycles
) (
    input wire clk, // Bench clock
    input wire sda, // Resolved data line
    output reg scl, // Serial clock, stands high outside frames
    output reg sda_n, // Data release, low pulls low
    output reg res_stb, // Result strobe, one cycle
    output reg [7:0] res_val // Acknowledge bit or read byte
);
    initial begin
        scl = 1'b1;
        sda_n = 1'b1;
        res_stb = 1'b0;
        res_val = 8'h00;
    end
    task wait_n(input integer n);
        repeat (n) @(negedge clk);
    endtask
    // Low phase with data set, then rise to mid high
    task phase(input v);
        begin
            wait_n(4);
            sda_n <= v;
            wait_n(LOW);
            scl <= 1'b1;
            wait_n(HIGH / 2);
        end
    endtask
    // Start, also repeated start; bus idle first
    task start;
        begin
            phase(1'b1);
            sda_n <= 1'b0;
            wait_n(HIGH / 2);
            scl <= 1'b0;
        end
    endtask
    task stop;
        begin
            phase(1'b0);
            sda_n <= 1'b1;
            wait_n(HIGH);
        end
    endtask
    // One clock pulse per bit, sampled mid high
    task bitx(input b, output s);
        begin
            phase(b);
            s = sda;
            wait_n(HIGH / 2);
            scl <= 1'b0;
        end
    endtask
    task post(input [7:0] v);
        begin
            res_val <= v;
            res_stb <= 1'b1;
            wait_n(1);
            res_stb <= 1'b0;
        end
    endtask
    // Eight bits MSB first, then released slot
    task wbyte(input [7:0] b);
        integer i;
        reg a;
        begin
            for (i = 7; i >= 0; i = i - 1) bitx(b[i], a);
            bitx(1'b1, a);
            post({7'h00, a});
        end
    endtask
    // Read byte; acknowledge only when more is wanted
    task rbyte(input more);
        integer i;
        reg [7:0] d;
        reg a;
        begin
            for (i = 7; i >= 0; i = i - 1) bitx(1'b1, d[i]);
            bitx(!more, a);
            post(d);
        end
    endtask
endmodule // eep_master

//--- dv/test_eep_slave.sv
// Self-checking bench for the two-wire memory slave port
`timescale 1ns/1ps
`include "eep_consts.vh"
module test_eep_slave;
    reg clock = 1'b0; // 250 MHz clock
    reg srst = 1'b1; // Synchronous reset
    reg [2:0] strap = 3'h0; // Address straps
    wire scl, sda_n, res_stb, sda_o, sda_oe_n, busy; // Bus and status nets
    wire [7:0] res_val, pointer; // Result and pointer
    wire sda = sda_n & (sda_oe_n | sda_o); // Pulled-up wired data line
    integer fail_count = 0, checks = 0; // Tallies
    reg [8:0] exp_q[$]; // Expected results, oldest first
    reg [8:0] e; // Note under comparison
    reg [7:0] a, d0, d1, d2, d3; // Word address and data
    reg [6:0] dev; // Slave address
    eep_slave #(.MS_CYCLES(100)) u_dut (.CLOCK(clock), .SRST(srst), .SCL_I(scl), .SDA_I(sda), .SDA_O(sda_o),
        .SDA_OE_N(sda_oe_n), .CHIP_SELECT_STRAP_0(strap[0]), .CHIP_SELECT_STRAP_1(strap[1]),
        .CHIP_SELECT_STRAP_2(strap[2]), .PROGRAM_TIMER_CONSTANT_INPUT(1'b1), .BUSY(busy), .POINTER(pointer));
    eep_master u_mst (.clk(clock), .sda(sda), .scl(scl), .sda_n(sda_n), .res_stb(res_stb), .res_val(res_val));
    initial begin
        forever #2 clock = ~clock;
    end
    task cmp_bit(input [79:0] n, input x, input g);
        begin
            checks = checks + 1;
            if (g !== x) begin
                fail_count = fail_count + 1;
                $display("unexpected %0s: expected %b seen %b", n, x, g);
            end
        end
    endtask
    task cmp_byte(input [79:0] n, input [7:0] x, input [7:0] g);
        begin
            checks = checks + 1;
            if (g !== x) begin
                fail_count = fail_count + 1;
                $display("unexpected %0s: expected %h seen %h", n, x, g);
            end
        end
    endtask
    task tally_and_finish;
        begin
            $display("checks %0d fail_count %0d", checks, fail_count);
            if (fail_count == 0 && checks > 0) begin
                $display("RESULT: PASS");
            end else begin
                $display("RESULT: FAIL");
            end
            $finish;
        end
    endtask
    task send(input [7:0] b, input nack);
        begin
            exp_q.push_back({1'b0, 7'h00, nack});
            u_mst.wbyte(b);
        end
    endtask
    task recv(input [7:0] x, input more);
        begin
            exp_q.push_back({1'b1, x});
            u_mst.rbyte(more);
        end
    endtask
    task wait_idle;
        integer i;
        begin
            for (i = 0; i < 8000 && busy !== 1'b0; i = i + 1) @(negedge clock);
            cmp_bit("busy end", 1'b0, busy);
        end
    endtask
    // Result watcher takes the oldest note per result
    always @(posedge clock) begin
        if (res_stb === 1'b1) begin
            e = exp_q.pop_front();
            if (e[8]) begin
                cmp_byte("read data", e[7:0], res_val);
            end else begin
                cmp_bit("ack", e[0], res_val[0]);
            end
        end
    end
    initial begin
        repeat (80000) @(posedge clock);
        fail_count = fail_count + 1;
        tally_and_finish;
    end
    initial begin
        a = $urandom(55);
        strap = $urandom;
        {a, d0, d1, d2} = $urandom;
        d3 = $urandom;
        dev = {`EEP_DEV_TYPE, strap};
        repeat (10) @(negedge clock);
        srst = 1'b0;
        repeat (3) @(negedge clock);
        u_mst.start;
        send({dev ^ 7'h01, 1'b0}, 1'b1);
        u_mst.stop;
        u_mst.start;
        send({dev, 1'b0}, 1'b0);
        send(a, 1'b0);
        send(d0, 1'b0);
        u_mst.stop;
        repeat (8) @(negedge clock);
        cmp_bit("busy", 1'b1, busy);
        cmp_byte("pointer", a + 8'h01, pointer);
        u_mst.start;
        send({dev, 1'b1}, 1'b1);
        u_mst.stop;
        wait_idle;
        u_mst.start;
        send({dev, 1'b0}, 1'b0);
        send(a, 1'b0);
        u_mst.start;
        send({dev, 1'b1}, 1'b0);
        recv(d0, 1'b0);
        u_mst.stop;
        u_mst.start;
        send({dev, 1'b0}, 1'b0);
        send(8'hff, 1'b0);
        send(d1, 1'b0);
        send(d2, 1'b0);
        send(d3, 1'b1);
        u_mst.stop;
        wait_idle;
        cmp_byte("pointer", 8'h01, pointer);
        u_mst.start;
        send({dev, 1'b0}, 1'b0);
        send(8'hff, 1'b0);
        u_mst.start;
        send({dev, 1'b1}, 1'b0);
        recv(d1, 1'b0);
        u_mst.stop;
        cmp_byte("pointer", 8'h00, pointer);
        u_mst.start;
        send({dev, 1'b1}, 1'b0);
        recv(d2, 1'b0);
        u_mst.stop;
        cmp_byte("pointer", 8'h01, pointer);
        tally_and_finish;
    end
endmodule // test_eep_slave
